// ==== design/adcc_pkg.sv ====
// constants, types and register map of the converter control slice
// How it works
// RULE_01: thermal sensor enable bit powers sensor
// RULE_02: group select picks event channel group
// RULE_03: action 000 ignores, 001 starts channel 0
// RULE_04: action 110 event flushes then starts
// RULE_05: divider code gives divide by 4..512
// RULE_06: done or compare hit sets flag
// RULE_07: vector ack or write one clears flag
// RULE_08: low byte read latches high byte
// RULE_09: byte latch is ordinary read/write register
// RULE_10: sampling lasts value plus one half periods
// RULE_11: twelve bit calibration, low byte register
// RULE_12: result word read through byte latch
// RULE_13: left adjusted twelve bit placement
// RULE_14: right adjusted, sign nibble when signed
// RULE_15: eight bit mode, sign byte when signed
// RULE_16: software writes reserved bits as zero
// RULE_17: reserved actions behave like no events
// RULE_18: flush aborts conversion, restarts clock
// RULE_19: signed select bit, unsigned after reset
// RULE_20: resolution field selects result format
package adcc_pkg;

	// ------------------------------------------------------------
	// register indices, byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [5:0] IDX_REF_CONTROL  = 6'h02;
	localparam logic [5:0] IDX_EVENT_CTRL   = 6'h03;
	localparam logic [5:0] IDX_CLOCK_DIV    = 6'h04;
	localparam logic [5:0] IDX_INT_FLAG     = 6'h06;
	localparam logic [5:0] IDX_BYTE_LATCH   = 6'h07;
	localparam logic [5:0] IDX_SAMPLING     = 6'h08;
	localparam logic [5:0] IDX_CAL_LOW      = 6'h0C;
	localparam logic [5:0] IDX_CAL_HIGH     = 6'h0D;
	localparam logic [5:0] IDX_RESULT_LOW   = 6'h10;
	localparam logic [5:0] IDX_RESULT_HIGH  = 6'h11;
	localparam logic [5:0] IDX_CONV_CONTROL = 6'h12;

	// ------------------------------------------------------------
	// field positions and codes
	// ------------------------------------------------------------
	localparam int          CTL_ENABLE_BIT  = 0;
	localparam int          CTL_FLUSH_BIT   = 1;
	localparam int          CTL_START_BIT   = 2;
	localparam int          CTL_CMP_BIT     = 3;
	localparam int          CTL_SIGNED_BIT  = 4;
	localparam int          CTL_RES_LSB     = 5;
	localparam logic [2:0]  ACT_NONE        = 3'h0;
	localparam logic [2:0]  ACT_CH0         = 3'h1;
	localparam logic [2:0]  ACT_SWEEP       = 3'h6;
	localparam logic [1:0]  RES_12_RIGHT    = 2'h0;
	localparam logic [1:0]  RES_8_RIGHT     = 2'h2;
	localparam logic [1:0]  RES_12_LEFT     = 2'h3;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
	localparam logic [7:0]  RESET_BYTE      = 8'h00;

	// ------------------------------------------------------------
	// timing: converter clock half periods spent converting after sampling
	// ------------------------------------------------------------
	localparam logic [4:0]  CONV_HALF_TICKS = 5'd24;

	typedef enum logic [1:0] {SEQ_IDLE, SEQ_SAMPLE, SEQ_CONVERT} adcc_seq_e;

	// signals handed to the analog converter
	typedef struct packed {
		logic        conv_clk;
		logic        sample_phase;
		logic        convert_phase;
		logic        thermal_sensor_enable;
		logic [11:0] calibration_value;
	} adcc_conv_out_s;

	// complete state of the block
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        aw_held;
		logic [5:0]  aw_idx;
		logic        w_held;
		logic [7:0]  w_data;
		logic        w_lane0;
		logic        thermal_sensor_enable;
		logic [1:0]  event_group_select;
		logic [2:0]  event_action;
		logic [2:0]  divider_code;
		logic        channel0_done_flag;
		logic [7:0]  byte_latch;
		logic [5:0]  sample_length_value;
		logic [7:0]  cal_low;
		logic [3:0]  cal_high;
		logic        enable;
		logic        compare_mode;
		logic        signed_select;
		logic [1:0]  resolution;
		logic        start_pending;
		logic [11:0] conversion_result;
		adcc_seq_e   seq;
		logic [7:0]  div_cnt;
		logic [6:0]  phase_cnt;
		logic        conv_clk;
	} adcc_state_s;

endpackage

// ==== design/adcc_top.sv ====
// converter control slice: axi4-lite registers, event trigger, clock divider, sequencer
`timescale 1ns/10ps
module adcc_top
(
	// clock and reset
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	// axi4-lite write address and data
	input  wire logic                    awvalid,
	output logic                         awready,
	input  wire logic [7:0]              awaddr,
	input  wire logic                    wvalid,
	output logic                         wready,
	input  wire logic [31:0]             wdata,
	input  wire logic [3:0]              wstrb,
	// axi4-lite write response
	output logic                         bvalid,
	input  wire logic                    bready,
	output logic [1:0]                   bresp,
	// axi4-lite read
	input  wire logic                    arvalid,
	output logic                         arready,
	input  wire logic [7:0]              araddr,
	output logic                         rvalid,
	input  wire logic                    rready,
	output logic [31:0]                  rdata,
	output logic [1:0]                   rresp,
	// event routing network, one-cycle pulses
	input  wire logic [3:0]              event_in,
	// interrupt controller acknowledge of the channel 0 vector
	input  wire logic                    vector_ack,
	// analog converter side
	input  wire logic [11:0]             adc_data,
	input  wire logic                    compare_met,
	output adcc_pkg::adcc_conv_out_s     conv_out,
	output logic                         channel0_done_flag
);
	import adcc_pkg::*;

	adcc_state_s s_r;
	adcc_state_s s_nxt;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------

	// last count of the half period counter for a divider code
	function automatic logic [7:0] half_last(input logic [2:0] code);
		logic [8:0] len;
		len = 9'd2 << code; // see RULE_05
		half_last = 8'(len - 9'd1);
	endfunction

	// result word as software sees it, high byte in [15:8]
	function automatic logic [15:0] fmt_result(input logic [11:0] res, input logic [1:0] mode, input logic sgn);
		logic [15:0] w;
		w = '0;
		unique case (mode)
			RES_12_LEFT:
				w = {res, 4'h0}; // see RULE_13
			RES_8_RIGHT:
				w = {{8{sgn & res[7]}}, res[7:0]}; // see RULE_15
			default:
				w = {{4{sgn & res[11]}}, res}; // see RULE_14
		endcase
		fmt_result = w;
	endfunction

	// register read view; reserved bits come back as zero
	function automatic logic [7:0] reg_view(input adcc_state_s st, input logic [5:0] idx);
		logic [7:0]  v;
		logic [15:0] w;
		v = RESET_BYTE;
		// a function result cannot be sliced directly, so the word is held first
		w = fmt_result(st.conversion_result, st.resolution, st.signed_select);
		unique case (idx)
			IDX_REF_CONTROL:  v = {7'h00, st.thermal_sensor_enable};
			IDX_EVENT_CTRL:   v = {3'h0, st.event_group_select, st.event_action}; // see RULE_16
			IDX_CLOCK_DIV:    v = {5'h00, st.divider_code};
			IDX_INT_FLAG:     v = {7'h00, st.channel0_done_flag};
			IDX_BYTE_LATCH:   v = st.byte_latch; // see RULE_09
			IDX_SAMPLING:     v = {2'h0, st.sample_length_value};
			IDX_CAL_LOW:      v = st.cal_low;
			IDX_CAL_HIGH:     v = {4'h0, st.cal_high};
			IDX_RESULT_LOW:   v = w[7:0];
			IDX_RESULT_HIGH:  v = st.byte_latch; // see RULE_12
			IDX_CONV_CONTROL: v = {1'b0, st.resolution, st.signed_select, st.compare_mode,
			                       st.start_pending, 1'b0, st.enable};
			default:          v = RESET_BYTE;
		endcase
		reg_view = v;
	endfunction

	function automatic logic idx_mapped(input logic [5:0] idx);
		idx_mapped = idx inside {IDX_REF_CONTROL, IDX_EVENT_CTRL, IDX_CLOCK_DIV, IDX_INT_FLAG,
		                         IDX_BYTE_LATCH, IDX_SAMPLING, IDX_CAL_LOW, IDX_CAL_HIGH,
		                         IDX_RESULT_LOW, IDX_RESULT_HIGH, IDX_CONV_CONTROL};
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------

	// one process computes the whole next state so all effects share one cycle
	always_comb
	begin
		logic        sel_event;
		logic        ev_start;
		logic        ev_flush;
		logic        sw_flush;
		logic        flush;
		logic        half_tick;
		logic        conv_done;
		logic        flag_clear;
		logic        do_write;
		logic [5:0]  r_idx;
		logic [15:0] word;
		sel_event  = 1'b0;
		ev_start   = 1'b0;
		ev_flush   = 1'b0;
		sw_flush   = 1'b0;
		flush      = 1'b0;
		half_tick  = 1'b0;
		conv_done  = 1'b0;
		flag_clear = vector_ack; // see RULE_07
		do_write   = 1'b0;
		r_idx      = araddr[7:2];
		word       = '0;
		s_nxt      = s_r;

		// write response handshake completes
		if (s_r.bvalid && bready)
			s_nxt.bvalid = 1'b0;
		// write address and data may arrive in either order
		if (awvalid && s_r.awready)
		begin
			s_nxt.aw_held = 1'b1;
			s_nxt.aw_idx  = awaddr[7:2];
		end
		if (wvalid && s_r.wready)
		begin
			s_nxt.w_held  = 1'b1;
			s_nxt.w_data  = wdata[7:0];
			s_nxt.w_lane0 = wstrb[0];
		end
		do_write = s_r.aw_held && s_r.w_held && !s_r.bvalid;

		// register write effects, only the low byte lane carries data
		if (do_write)
		begin
			s_nxt.aw_held = 1'b0;
			s_nxt.w_held  = 1'b0;
			s_nxt.bvalid  = 1'b1;
			s_nxt.bresp   = idx_mapped(s_r.aw_idx) ? RESP_OKAY : RESP_SLVERR;
			if (s_r.w_lane0)
			begin
				unique case (s_r.aw_idx)
					IDX_REF_CONTROL:
						s_nxt.thermal_sensor_enable = s_r.w_data[0]; // see RULE_01
					IDX_EVENT_CTRL:
					begin
						s_nxt.event_group_select = s_r.w_data[4:3];
						s_nxt.event_action       = s_r.w_data[2:0];
					end
					IDX_CLOCK_DIV:
						s_nxt.divider_code = s_r.w_data[2:0];
					IDX_INT_FLAG:
						flag_clear = flag_clear | s_r.w_data[0]; // see RULE_07
					IDX_BYTE_LATCH:
						s_nxt.byte_latch = s_r.w_data; // see RULE_09
					IDX_SAMPLING:
						s_nxt.sample_length_value = s_r.w_data[5:0];
					IDX_CAL_LOW:
						s_nxt.cal_low = s_r.w_data; // see RULE_11
					IDX_CAL_HIGH:
						s_nxt.cal_high = s_r.w_data[3:0]; // see RULE_11
					IDX_CONV_CONTROL:
					begin
						s_nxt.enable        = s_r.w_data[CTL_ENABLE_BIT];
						s_nxt.compare_mode  = s_r.w_data[CTL_CMP_BIT];
						s_nxt.signed_select = s_r.w_data[CTL_SIGNED_BIT]; // see RULE_19
						s_nxt.resolution    = s_r.w_data[CTL_RES_LSB +: 2]; // see RULE_20
						sw_flush            = s_r.w_data[CTL_FLUSH_BIT]; // see RULE_18
						if (s_r.w_data[CTL_START_BIT])
							s_nxt.start_pending = 1'b1;
					end
					default:
						s_nxt.bresp = RESP_SLVERR;
				endcase
			end
		end

		// read channel; a low byte read captures the matching high byte
		if (s_r.rvalid && rready)
			s_nxt.rvalid = 1'b0;
		if (arvalid && s_r.arready)
		begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata  = {24'h000000, reg_view(s_r, r_idx)};
			s_nxt.rresp  = idx_mapped(r_idx) ? RESP_OKAY : RESP_SLVERR;
			word         = fmt_result(s_r.conversion_result, s_r.resolution, s_r.signed_select);
			if (r_idx == IDX_RESULT_LOW)
				s_nxt.byte_latch = word[15:8]; // see RULE_08
			else if (r_idx == IDX_CAL_LOW)
				s_nxt.byte_latch = {4'h0, s_r.cal_high}; // see RULE_08
		end

		// event trigger: lowest channel of the chosen group drives channel 0
		sel_event = event_in[s_r.event_group_select]; // see RULE_02
		unique case (s_r.event_action)
			ACT_CH0:   ev_start = sel_event; // see RULE_03
			ACT_SWEEP: ev_flush = sel_event; // see RULE_04
			default:   ev_start = 1'b0; // see RULE_17
		endcase
		if (ev_start || ev_flush)
			s_nxt.start_pending = 1'b1;
		flush = sw_flush || ev_flush;

		// converter clock divider, one tick per half period
		if (s_r.enable)
		begin
			if (s_r.div_cnt == half_last(s_r.divider_code)) // see RULE_05
			begin
				s_nxt.div_cnt  = 8'h00;
				s_nxt.conv_clk = ~s_r.conv_clk;
				half_tick      = 1'b1;
			end
			else
				s_nxt.div_cnt = s_r.div_cnt + 8'd1;
		end

		// conversion sequencer
		unique case (s_r.seq)
			SEQ_IDLE:
				if (s_r.enable && s_r.start_pending)
				begin
					s_nxt.seq           = SEQ_SAMPLE;
					s_nxt.phase_cnt     = 7'h00;
					s_nxt.start_pending = ev_start || ev_flush;
				end
			SEQ_SAMPLE:
				if (half_tick)
				begin
					// sampling spans value plus one half periods
					if (s_r.phase_cnt == {1'b0, s_r.sample_length_value}) // see RULE_10
					begin
						s_nxt.seq       = SEQ_CONVERT;
						s_nxt.phase_cnt = 7'h00;
					end
					else
						s_nxt.phase_cnt = s_r.phase_cnt + 7'd1;
				end
			SEQ_CONVERT:
				if (half_tick)
				begin
					if (s_r.phase_cnt == 7'(CONV_HALF_TICKS - 5'd1))
					begin
						s_nxt.seq = SEQ_IDLE;
						conv_done = 1'b1;
					end
					else
						s_nxt.phase_cnt = s_r.phase_cnt + 7'd1;
				end
		endcase
		if (!s_r.enable)
			s_nxt.seq = SEQ_IDLE;

		// capture the result when a conversion completes
		if (conv_done)
			s_nxt.conversion_result = (s_r.resolution == RES_8_RIGHT) ? {4'h0, adc_data[7:0]} : adc_data;

		// flush throws the running conversion away and restarts the clock; pending starts survive
		if (flush) // see RULE_18
		begin
			s_nxt.seq       = SEQ_IDLE;
			s_nxt.div_cnt   = 8'h00;
			s_nxt.conv_clk  = 1'b0;
			s_nxt.phase_cnt = 7'h00;
			conv_done       = 1'b0;
			s_nxt.conversion_result = s_r.conversion_result;
			// a pending start enters sampling with the clock restart, so the event timing is exact
			if (s_r.enable && (s_r.start_pending || s_nxt.start_pending)) // see RULE_04
			begin
				s_nxt.seq           = SEQ_SAMPLE;
				s_nxt.start_pending = 1'b0;
			end
		end

		// done flag: a set in the same cycle as a clear wins
		s_nxt.channel0_done_flag = (s_r.channel0_done_flag & ~flag_clear)
		                         | (conv_done & (~s_r.compare_mode | compare_met)); // see RULE_06

		// ready outputs are registered, so they reflect room for the next cycle
		s_nxt.awready = !s_nxt.aw_held && !s_nxt.bvalid;
		s_nxt.wready  = !s_nxt.w_held && !s_nxt.bvalid;
		s_nxt.arready = !s_nxt.rvalid;
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------

	// synchronous reset clears every field, readies rise one cycle later
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_r     <= '0;
			s_r.seq <= SEQ_IDLE;
		end
		else
			s_r <= s_nxt;
	end

	// ------------------------------------------------------------
	// outputs, all taken straight from the state register
	// ------------------------------------------------------------
	assign awready = s_r.awready;
	assign wready  = s_r.wready;
	assign bvalid  = s_r.bvalid;
	assign bresp   = s_r.bresp;
	assign arready = s_r.arready;
	assign rvalid  = s_r.rvalid;
	assign rdata   = s_r.rdata;
	assign rresp   = s_r.rresp;

	// converter side: sensor enable and calibration go to the analog macro
	assign conv_out.conv_clk              = s_r.conv_clk;
	assign conv_out.sample_phase          = (s_r.seq == SEQ_SAMPLE);
	assign conv_out.convert_phase         = (s_r.seq == SEQ_CONVERT);
	assign conv_out.thermal_sensor_enable = s_r.thermal_sensor_enable; // see RULE_01
	assign conv_out.calibration_value     = {s_r.cal_high, s_r.cal_low}; // see RULE_11
	assign channel0_done_flag             = s_r.channel0_done_flag;

endmodule

// ==== test/adcc_assertions.sv ====
// port checker for the converter control slice
`timescale 1ns/10ps
module adcc_assertions
(
	// clock and reset
	input wire logic                     aclk,
	input wire logic                     aresetn,
	// bus handshakes and read data
	input wire logic                     awready,
	input wire logic                     bvalid,
	input wire logic                     bready,
	input wire logic                     rvalid,
	input wire logic                     rready,
	input wire logic [31:0]              rdata,
	// flag and converter side
	input wire logic                     vector_ack,
	input wire adcc_pkg::adcc_conv_out_s conv_out,
	input wire logic                     channel0_done_flag
);
	import adcc_pkg::*;
	// ----------------------------------------
	// properties, all on aclk
	// ----------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_b_stands: assert property (bvalid && !bready |=> bvalid)
		else $error("write response dropped early");
	chk_r_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer dropped or changed");
	chk_aw_refused: assert property (bvalid |-> !awready)
		else $error("write address accepted while answering");
	chk_rdata_zero: assert property (rvalid |-> rdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	chk_flag_rise: assert property ($rose(channel0_done_flag) |-> $past(conv_out.convert_phase))
		else $error("flag set outside a conversion end");
	// flag drops only after an acknowledge or a completed write
	chk_flag_clear: assert property ($fell(channel0_done_flag) |-> $past(vector_ack) || $rose(bvalid))
		else $error("flag cleared without cause");
	chk_phase_excl: assert property (!(conv_out.sample_phase && conv_out.convert_phase))
		else $error("sample and convert overlap");
	chk_sample_first: assert property ($rose(conv_out.convert_phase) |-> $past(conv_out.sample_phase))
		else $error("convert without sampling");
	chk_thermal_wr: assert property ($changed(conv_out.thermal_sensor_enable) |-> $rose(bvalid))
		else $error("sensor enable moved without a write");
	chk_cal_wr: assert property ($changed(conv_out.calibration_value) |-> $rose(bvalid))
		else $error("calibration moved without a write");
	cover property ($rose(channel0_done_flag));
	cover property ($rose(conv_out.convert_phase));
	cover property (rvalid && rready);
endmodule

bind adcc_top adcc_assertions u_chk
(
	.aclk(aclk), .aresetn(aresetn), .awready(awready), .bvalid(bvalid), .bready(bready),
	.rvalid(rvalid), .rready(rready), .rdata(rdata), .vector_ack(vector_ack),
	.conv_out(conv_out), .channel0_done_flag(channel0_done_flag)
);

// ==== test/adcc_partner.sv ====
// analog converter model facing the conversion outputs
`timescale 1ns/10ps
module adcc_partner
(
	// clock
	input wire logic                     aclk,
	// controls from the block
	input wire adcc_pkg::adcc_conv_out_s conv_out,
	// bench choice of the next result
	input wire logic [11:0]              sample_value,
	input wire logic                     cmp_level,
	// converter answers
	output logic [11:0]                  adc_data,
	output logic                         compare_met
);
	import adcc_pkg::*;
	logic [11:0] pat_r = 12'hA5A;
	// toggling pattern outside conversion, so a mistimed capture cannot match
	always_ff @(posedge aclk)
	begin
		pat_r <= ~pat_r;
	end
	// result and compare outcome only while converting
	assign adc_data    = conv_out.convert_phase ? sample_value : pat_r;
	assign compare_met = conv_out.convert_phase & cmp_level;
endmodule

// ==== test/adc_event_clock_result_regs_tb.sv ====
// self-checking bench: registers, event conversions, result formats, flush
`timescale 1ns/10ps
module adc_event_clock_result_regs_tb;
	import adcc_pkg::*;
	logic           aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, vector_ack, cmp_level;
	logic [7:0]     awaddr, araddr;
	logic [31:0]    wdata, rdata;
	logic [3:0]     wstrb, event_in;
	logic [11:0]    sample_value, adc_data;
	logic           awready, wready, bvalid, arready, rvalid, compare_met, channel0_done_flag;
	logic [1:0]     bresp, rresp;
	adcc_conv_out_s conv_out;
	int             bad_count, compares, n;
	// expected low and high bytes per format, entry 0 in the low bits
	localparam logic [39:0] LO_T = 40'hC0C5C5BCBC;
	localparam logic [39:0] HI_T = 40'hABFF00FA0A;
	localparam logic [9:0]  RES_T = 10'h3A0;
	localparam logic [29:0] RW_I = {IDX_CAL_LOW, IDX_BYTE_LATCH, IDX_SAMPLING, IDX_CLOCK_DIV, IDX_EVENT_CTRL};
	localparam logic [39:0] RW_V = 40'h5AA53F071F;

	adcc_top DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
		.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
		.rready(rready), .rdata(rdata), .rresp(rresp), .event_in(event_in), .vector_ack(vector_ack),
		.adc_data(adc_data), .compare_met(compare_met), .conv_out(conv_out),
		.channel0_done_flag(channel0_done_flag));
	adcc_partner u_conv (.aclk(aclk), .conv_out(conv_out), .sample_value(sample_value),
		.cmp_level(cmp_level), .adc_data(adc_data), .compare_met(compare_met));

	// ----------------------------------------
	// clock, helpers and bus tasks
	// ----------------------------------------
	initial
	begin
		aclk = 1'h0;
		forever #4 aclk = ~aclk;
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// address and data offered together, each released when taken
	task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
		@(posedge aclk);
		awvalid <= 1'h1;
		wvalid  <= 1'h1;
		awaddr  <= {idx, 2'h0};
		wdata   <= {24'h0, d};
		bready  <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end
		while ((awvalid && !awready) || (wvalid && !wready));
		do @(posedge aclk); while (!bvalid);
		bready <= 1'h0;
		check("write response", bresp, er);
	endtask
	task automatic rd(input logic [5:0] idx, input logic [7:0] exp, input logic [1:0] er);
		@(posedge aclk);
		arvalid <= 1'h1;
		araddr  <= {idx, 2'h0};
		rready  <= 1'h1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'h0;
		do @(posedge aclk); while (!rvalid);
		rready <= 1'h0;
		check($sformatf("read data %h", idx), rdata, {24'h0, exp});
		check("read response", rresp, er);
	endtask
	task automatic pulse(input logic [3:0] m);
		@(posedge aclk);
		event_in <= m;
		@(posedge aclk);
		event_in <= 4'h0;
	endtask
	// one event conversion; k picks divider code, group and result format
	task automatic run(input int k);
		int i;
		int c;
		logic f;
		i = k % 5;
		f = (i != 0) || (k == 5);
		sample_value <= (i == 2 || i == 3) ? 12'h0C5 : 12'hABC;
		cmp_level <= (k == 5);
		wr(IDX_CLOCK_DIV, {5'h0, k[2:0]}, RESP_OKAY);
		wr(IDX_SAMPLING, {5'h0, k[2:0]}, RESP_OKAY);
		wr(IDX_CONV_CONTROL, {1'h0, RES_T[2*i+:2], i == 1 || i == 3, i == 0, 3'h1}, RESP_OKAY);
		wr(IDX_EVENT_CTRL, {3'h0, k[1:0], (k == 8) ? ACT_CH0 : ACT_SWEEP}, RESP_OKAY);
		pulse(~(4'h1 << k[1:0]));
		repeat (6) @(negedge aclk);
		check("start on foreign group", conv_out.sample_phase, 1'h0);
		pulse(4'h1 << k[1:0]);
		c = 0;
		while (!conv_out.sample_phase && c < 40)
		begin
			@(negedge aclk);
			c++;
		end
		if (k < 8) check("clock restart", conv_out.conv_clk, 1'h0);
		c = 0;
		while (conv_out.sample_phase && c < 9000)
		begin
			@(negedge aclk);
			c++;
		end
		if (k < 8) check("sample length", c, (k + 1) * (2 << k));
		if (k < 8) check("clock at convert", conv_out.conv_clk, !k[0]);
		c = 0;
		while (conv_out.convert_phase && c < 9000)
		begin
			@(negedge aclk);
			c++;
		end
		if (k < 8) check("convert length", c, CONV_HALF_TICKS * (2 << k));
		check("done flag", channel0_done_flag, f);
		rd(IDX_RESULT_LOW, LO_T[8*i+:8], RESP_OKAY);
		rd(IDX_RESULT_HIGH, HI_T[8*i+:8], RESP_OKAY);
		rd(IDX_BYTE_LATCH, HI_T[8*i+:8], RESP_OKAY);
		wr(IDX_INT_FLAG, 8'h00, RESP_OKAY);
		check("flag after zero write", channel0_done_flag, f);
		if (k[0])
			wr(IDX_INT_FLAG, 8'h01, RESP_OKAY);
		else
			@(posedge aclk) vector_ack <= 1'h1;
		@(posedge aclk) vector_ack <= 1'h0;
		@(negedge aclk);
		check("flag after clear", channel0_done_flag, 1'h0);
	endtask

	// ----------------------------------------
	// watchdog and main sequence
	// ----------------------------------------
	initial
	begin
		repeat (60000) @(posedge aclk);
		bad_count++;
		close_out;
	end
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, vector_ack, cmp_level} = 8'h00;
		{awaddr, araddr, wdata, sample_value} = 60'h0;
		wstrb    = 4'hF;
		event_in = 4'h0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		for (int r = 0; r < 5; r++) rd(RW_I[6*r+:6], 8'h00, RESP_OKAY);
		rd(IDX_INT_FLAG, 8'h00, RESP_OKAY);
		wr(IDX_CAL_HIGH, 8'h03, RESP_OKAY);
		for (int r = 0; r < 5; r++)
		begin
			wr(RW_I[6*r+:6], RW_V[8*r+:8], RESP_OKAY);
			rd(RW_I[6*r+:6], RW_V[8*r+:8], RESP_OKAY);
		end
		rd(IDX_BYTE_LATCH, 8'h03, RESP_OKAY);
		wstrb <= 4'hE;
		wr(IDX_SAMPLING, 8'h15, RESP_OKAY);
		wstrb <= 4'hF;
		rd(IDX_SAMPLING, 8'h3F, RESP_OKAY);
		check("calibration", conv_out.calibration_value, 12'h35A);
		wr(IDX_REF_CONTROL, 8'h01, RESP_OKAY);
		check("sensor enable", conv_out.thermal_sensor_enable, 1'h1);
		wr(6'h3F, 8'h00, RESP_SLVERR);
		rd(6'h3F, 8'h00, RESP_SLVERR);
		$display("register test done");
		wr(IDX_CONV_CONTROL, 8'h01, RESP_OKAY);
		for (int a = 0; a < 8; a++)
		begin
			if (a != 1 && a != 6)
			begin
				wr(IDX_EVENT_CTRL, a[7:0], RESP_OKAY);
				pulse(4'hF);
				repeat (6) @(negedge aclk);
				check("reserved action start", conv_out.sample_phase, 1'h0);
			end
		end
		$display("event action test done");
		for (int k = 0; k < 9; k++) run(k);
		$display("conversion test done");
		wr(IDX_CLOCK_DIV, 8'h02, RESP_OKAY);
		wr(IDX_EVENT_CTRL, 8'h01, RESP_OKAY);
		pulse(4'h1);
		n = 0;
		while (!conv_out.convert_phase && n < 400)
		begin
			@(negedge aclk);
			n++;
		end
		check("convert before flush", conv_out.convert_phase, 1'h1);
		wr(IDX_CONV_CONTROL, 8'h03, RESP_OKAY);
		@(negedge aclk);
		check("convert after flush", conv_out.convert_phase, 1'h0);
		check("flag after flush", channel0_done_flag, 1'h0);
		$display("flush test done");
		close_out;
	end
endmodule
